// >>> rcd_pkg.sv
// Constants and types shared by the router command decoder
// How it works
// - Operation command: framing E0/E2, address, 0x5A, then exactly two data bytes.
// - Operation data decode into a channel change or a router sleep.
// - Change: data1[7:5] router, [4:2] feed, data1[1:0]:data2 tuning word.
// - data1[1:0] zero and data2 zero put the named router to sleep.
// - Feed bit 0 high band, bit 1 horizontal, bit 2 satellite B.
// - Legacy matrix application serves satellite A only; satellite B feeds dropped.
// - Installation command: framing E0/E2, address, 0x5B, two data bytes, three operations.
// - Application probe: tone at passband centre on id match, else 20 MHz higher.
// - Oscillator probe: tone at passband centre on set match, else 20 MHz higher.
// - Signal-on: every router emits a tone at its own passband centre.
// - Application id is a stored byte, default 0x04, compared with data2.
// - Passband parameter is half the centre frequency in MHz; sets tone.
// - Commands to the configured address (default 0x11) or to 0x00 accepted.
package rcd_pkg;

  localparam int ROUTERS = 8;
  localparam int TONE_W  = 18;

  localparam logic [7:0] FRAMING_NO_REPLY   = 8'hE0;
  localparam logic [7:0] FRAMING_REPLY      = 8'hE2;
  localparam logic [7:0] CMD_OPERATION      = 8'h5A;
  localparam logic [7:0] CMD_INSTALLATION   = 8'h5B;
  localparam logic [7:0] BROADCAST_ADDR     = 8'h00;
  localparam logic [7:0] SLAVE_ADDR_RESET   = 8'h11;
  localparam logic [7:0] APPLICATION_ID_RST = 8'h04;
  localparam logic [7:0] DATA_ZERO          = 8'h00;
  localparam logic [2:0] FRAME_BYTES        = 3'h5;
  localparam logic [2:0] FEED_ZERO          = 3'h0;
  localparam logic [1:0] SUB_ZERO           = 2'h0;
  localparam logic [1:0] SUB_APP            = 2'h1;
  localparam logic [1:0] SUB_OSC            = 2'h2;
  localparam logic [TONE_W-1:0] TONE_MISS_OFFSET_MHZ = 18'h0_0014;

  // Field positions inside data1
  localparam int ROUTER_MSB = 7;
  localparam int ROUTER_LSB = 5;
  localparam int FEED_MSB   = 4;
  localparam int FEED_LSB   = 2;
  localparam int SUB_MSB    = 1;
  localparam int SUB_LSB    = 0;

  typedef struct packed {
    logic [7:0] framing;
    logic [7:0] addr;
    logic [7:0] command;
    logic [7:0] data1;
    logic [7:0] data2;
  } rcd_cmd_t;

  // Feed code as seen by the RF input selector
  typedef struct packed {
    logic sat_b;
    logic pol_horizontal;
    logic band_high;
  } rcd_feed_t;

endpackage

// >>> rcd_frame_parser.sv
// Frame collector turning the received byte stream into one command word
`timescale 1ns/1ps
module rcd_frame_parser
(
  input  wire logic            core_clk,
  input  wire logic            rst,
  input  wire logic [7:0]      rx_byte,
  input  wire logic            rx_valid,
  input  wire logic            rx_end,
  output rcd_pkg::rcd_cmd_t    cmd_o,
  output logic                 cmd_valid_o
);
  import rcd_pkg::*;

  logic [2:0]  count_reg;
  logic [39:0] shift_reg;
  wire  [2:0]  count_next = (count_reg == 3'h7) ? count_reg : count_reg + 3'h1;

  // The counter saturates so a long frame never aliases to a legal length
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      count_reg   <= 3'h0;
      shift_reg   <= 40'h00_0000_0000;
      cmd_valid_o <= 1'b0;
      cmd_o       <= '0;
    end
    else
    begin
      cmd_valid_o <= 1'b0;
      if (rx_end)
      begin
        count_reg   <= 3'h0;
        cmd_valid_o <= (count_reg == FRAME_BYTES);
        cmd_o       <= shift_reg;
      end
      else if (rx_valid)
      begin
        count_reg <= count_next;
        shift_reg <= {shift_reg[31:0], rx_byte};
      end
    end
  end

endmodule

// >>> rcd_decoder.sv
// Router command decoder: operation and installation commands to router settings
`timescale 1ns/1ps
module rcd_decoder
(
  input  wire logic                                     core_clk,
  input  wire logic                                     rst,
  input  wire logic [7:0]                               rx_byte,
  input  wire logic                                     rx_valid,
  input  wire logic                                     rx_end,
  input  wire logic [7:0]                               slave_address,
  input  wire logic [7:0]                               application_id,
  input  wire logic [7:0]                               oscillator_set_id,
  input  wire logic                                     legacy_matrix_en,
  input  wire logic [rcd_pkg::ROUTERS-1:0][15:0]        passband_centre,
  output rcd_pkg::rcd_feed_t [rcd_pkg::ROUTERS-1:0]     router_feed,
  output logic [rcd_pkg::ROUTERS-1:0][9:0]              router_tune,
  output logic [rcd_pkg::ROUTERS-1:0]                   router_sleep,
  output logic [rcd_pkg::ROUTERS-1:0]                   router_tone_en,
  output logic [rcd_pkg::ROUTERS-1:0][rcd_pkg::TONE_W-1:0] router_tone_mhz,
  output logic                                          cmd_done,
  output logic                                          cmd_ignored
);
  import rcd_pkg::*;

  // ==========================================================
  // Frame capture
  rcd_cmd_t cmd;
  logic     cmd_valid;

  rcd_frame_parser u_parser
  (
    .core_clk    (core_clk),
    .rst         (rst),
    .rx_byte     (rx_byte),
    .rx_valid    (rx_valid),
    .rx_end      (rx_end),
    .cmd_o       (cmd),
    .cmd_valid_o (cmd_valid)
  );

  // ==========================================================
  // Command decode
  wire       framing_ok = (cmd.framing == FRAMING_NO_REPLY)
                        || (cmd.framing == FRAMING_REPLY);
  wire       addr_ok    = (cmd.addr == slave_address)
                        || (cmd.addr == BROADCAST_ADDR);
  wire       accept     = cmd_valid && framing_ok && addr_ok;
  wire [2:0] sel        = cmd.data1[ROUTER_MSB:ROUTER_LSB];
  wire [2:0] feed_code  = cmd.data1[FEED_MSB:FEED_LSB];
  wire [1:0] sub_code   = cmd.data1[SUB_MSB:SUB_LSB];
  wire [9:0] tune_word  = {sub_code, cmd.data2};
  wire       is_op      = accept && (cmd.command == CMD_OPERATION);
  wire       is_inst    = accept && (cmd.command == CMD_INSTALLATION);
  rcd_feed_t feed_fields;
  assign feed_fields = feed_code;

  wire sleep_code        = (sub_code == SUB_ZERO) && (cmd.data2 == DATA_ZERO);
  wire channel_change_op = is_op && !sleep_code
                         && !(legacy_matrix_en && feed_fields.sat_b);
  wire router_sleep_op   = is_op && sleep_code;
  wire inst_ok           = is_inst && (feed_code == FEED_ZERO);
  wire application_probe_op = inst_ok && (sub_code == SUB_APP);
  wire oscillator_probe_op  = inst_ok && (sub_code == SUB_OSC);
  wire all_routers_tone_op  = inst_ok && (sub_code == SUB_ZERO);
  wire probe_op    = application_probe_op || oscillator_probe_op;
  wire probe_match = application_probe_op ? (cmd.data2 == application_id)
                                          : (cmd.data2 == oscillator_set_id);
  wire any_action  = channel_change_op || router_sleep_op || probe_op
                   || all_routers_tone_op;

  // ==========================================================
  // Per-router settings
  genvar k;
  generate
    for (k = 0; k < ROUTERS; k = k + 1)
    begin : g_router
      wire                hit         = (sel == 3'(k));
      // Passband is held as half the centre frequency, so double it
      wire [TONE_W-1:0]   centre_mhz  = {1'b0, passband_centre[k], 1'b0};
      wire [TONE_W-1:0]   probe_mhz   = probe_match ? centre_mhz
                                        : centre_mhz + TONE_MISS_OFFSET_MHZ;
      wire                tone_set    = (probe_op && hit) || all_routers_tone_op;
      wire [TONE_W-1:0]   tone_next   = all_routers_tone_op ? centre_mhz : probe_mhz;

      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          router_feed[k]     <= '0;
          router_tune[k]     <= 10'h000;
          router_sleep[k]    <= 1'b0;
          router_tone_en[k]  <= 1'b0;
          router_tone_mhz[k] <= '0;
        end
        else if (channel_change_op && hit)
        begin
          router_feed[k]    <= feed_fields;
          router_tune[k]    <= tune_word;
          router_sleep[k]   <= 1'b0;
          router_tone_en[k] <= 1'b0;
        end
        else if (router_sleep_op && hit)
        begin
          router_sleep[k]   <= 1'b1;
          router_tone_en[k] <= 1'b0;
        end
        else if (tone_set)
        begin
          router_sleep[k]    <= 1'b0;
          router_tone_en[k]  <= 1'b1;
          router_tone_mhz[k] <= tone_next;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Completion strobes
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cmd_done    <= 1'b0;
      cmd_ignored <= 1'b0;
    end
    else
    begin
      cmd_done    <= any_action;
      cmd_ignored <= cmd_valid && !any_action;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_change_feed: assert property (channel_change_op |=>
    router_feed[$past(sel)] == $past(feed_code))
    else $error("channel change did not load the feed");

  a_change_tune: assert property (channel_change_op |=>
    router_tune[$past(sel)] == {$past(cmd.data1[1:0]), $past(cmd.data2)})
    else $error("channel change did not load the tuning word");

  a_sleep_set: assert property (router_sleep_op |=>
    router_sleep[$past(sel)] && !router_tone_en[$past(sel)])
    else $error("sleep command did not put router to sleep");

  a_app_match: assert property (application_probe_op && probe_match |=>
    router_tone_mhz[$past(sel)] == $past({1'b0, passband_centre[sel], 1'b0}))
    else $error("matching application probe tone not at centre");

  a_probe_miss: assert property (probe_op && !probe_match |=>
    router_tone_mhz[$past(sel)]
      == $past({1'b0, passband_centre[sel], 1'b0}) + TONE_MISS_OFFSET_MHZ)
    else $error("missed probe tone not 20 MHz high");

  a_all_tone: assert property (all_routers_tone_op |=>
    (&router_tone_en) && router_tone_mhz[0] == {1'b0, $past(passband_centre[0]), 1'b0})
    else $error("signal-on did not start every tone");

  a_bad_addr: assert property (cmd_valid && !addr_ok |=>
    $stable(router_sleep) && $stable(router_tone_en) && $stable(router_tune) ##0 cmd_ignored)
    else $error("foreign address changed router state");

  a_legacy_sat_b: assert property (legacy_matrix_en && is_op && feed_fields.sat_b |=>
    $stable(router_feed))
    else $error("legacy application took a satellite B feed");

  // Legacy satellite B changes are refused, so only acted-on operations strobe done
  a_done_pulse: assert property (channel_change_op || router_sleep_op |=> cmd_done ##1 !cmd_done)
    else $error("operation command completion strobe wrong");

endmodule

// >>> rcd_stb_model.sv
// Control bus master model that turns command words into the received byte stream
`timescale 1ns/1ps
module rcd_stb_model
(
  output logic [7:0] rx_byte,
  output logic       rx_valid,
  output logic       rx_end,
  input  wire logic  core_clk
);
  import rcd_pkg::*;

  initial
  begin
    rx_byte  = 8'h00;
    rx_valid = 1'b0;
    rx_end   = 1'b0;
  end

  // ==========================================================
  // Frame sender
  // Sends the first n bytes in order; gap idles a slow master between bytes.
  // The idle byte lane carries the inverse of the last byte so a stale value never matches.
  task automatic send(input rcd_pkg::rcd_cmd_t c, input int n, input int gap);
    logic [7:0] b;
    b = 8'h00;
    for (int k = 0; k < n; k++)
    begin
      b = c[39-8*k -: 8];
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_byte  <= b;
      repeat (gap)
      begin
        @(posedge core_clk);
        rx_valid <= 1'b0;
        rx_byte  <= ~b;
      end
    end
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_byte  <= ~b;
    rx_end   <= 1'b1;
    @(posedge core_clk);
    rx_end   <= 1'b0;
  endtask
endmodule

// >>> rcd_decoder_tb.sv
// Self-checking bench for the router command decoder
`timescale 1ns/1ps
module rcd_decoder_tb;
  import rcd_pkg::*;
  logic                               core_clk = 1'b0;
  logic                               rst = 1'b1;
  logic [7:0]                         rx_byte;
  logic                               rx_valid;
  logic                               rx_end;
  logic [7:0]                         slave_address = SLAVE_ADDR_RESET;
  logic [7:0]                         application_id = APPLICATION_ID_RST;
  logic [7:0]                         oscillator_set_id = 8'h03;
  logic                               legacy_matrix_en = 1'b0;
  logic [ROUTERS-1:0][15:0]           pb;
  rcd_feed_t [ROUTERS-1:0]            router_feed;
  logic [ROUTERS-1:0][9:0]            router_tune;
  logic [ROUTERS-1:0]                 router_sleep;
  logic [ROUTERS-1:0]                 router_tone_en;
  logic [ROUTERS-1:0][TONE_W-1:0]     router_tone_mhz;
  logic                               cmd_done;
  logic                               cmd_ignored;
  logic [2:0]                         e_feed [ROUTERS];
  logic [9:0]                         e_tune [ROUTERS];
  logic [17:0]                        e_tone [ROUTERS];
  logic [7:0]                         e_sleep;
  logic [7:0]                         e_ten;
  int                                 fail_count = 0;
  int                                 compares = 0;
  int                                 cycles = 0;

  rcd_stb_model stb (.core_clk(core_clk), .rx_byte(rx_byte), .rx_valid(rx_valid),
                     .rx_end(rx_end));
  rcd_decoder dut (.core_clk(core_clk), .rst(rst), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_end(rx_end), .slave_address(slave_address), .application_id(application_id),
    .oscillator_set_id(oscillator_set_id), .legacy_matrix_en(legacy_matrix_en),
    .passband_centre(pb), .router_feed(router_feed), .router_tune(router_tune),
    .router_sleep(router_sleep), .router_tone_en(router_tone_en),
    .router_tone_mhz(router_tone_mhz), .cmd_done(cmd_done), .cmd_ignored(cmd_ignored));

  always #50 core_clk = ~core_clk;

  // ==========================================================
  // Checking and closing
  task automatic close_out();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_routers();
    for (int i = 0; i < ROUTERS; i++)
    begin
      chk("feed", {15'h0, e_feed[i]}, {15'h0, router_feed[i]});
      chk("tune", {8'h00, e_tune[i]}, {8'h00, router_tune[i]});
      chk("sleep", {17'h0, e_sleep[i]}, {17'h0, router_sleep[i]});
      chk("tone_en", {17'h0, e_ten[i]}, {17'h0, router_tone_en[i]});
      if (e_ten[i])
        chk("tone_mhz", e_tone[i], router_tone_mhz[i]);
    end
  endtask

  // Outputs settle one edge after the edge that takes the end of frame
  task automatic run(input logic [7:0] fr, ad, cm, d1, d2, input logic act, input int gap);
    stb.send({fr, ad, cm, d1, d2}, 5, gap);
    @(posedge core_clk);
    #1;
    chk("done", {17'h0, act}, {17'h0, cmd_done});
    chk("ignored", {17'h0, ~act}, {17'h0, cmd_ignored});
    chk_routers();
  endtask

  task automatic change(input int r, input logic [2:0] f, input logic [9:0] t,
                        input logic [7:0] fr, ad);
    e_feed[r]  = f;
    e_tune[r]  = t;
    e_sleep[r] = 1'b0;
    e_ten[r]   = 1'b0;
    run(fr, ad, CMD_OPERATION, {3'(r), f, t[9:8]}, t[7:0], 1'b1, 0);
  endtask

  task automatic probe(input int r, input logic [1:0] sub, input logic [7:0] id, input logic hit);
    e_ten[r]   = 1'b1;
    e_sleep[r] = 1'b0;
    e_tone[r]  = {1'b0, pb[r], 1'b0} + (hit ? 18'h0 : TONE_MISS_OFFSET_MHZ);
    run(FRAMING_NO_REPLY, slave_address, CMD_INSTALLATION, {3'(r), FEED_ZERO, sub}, id, 1'b1, 1);
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      close_out();
    end
  end

  // ==========================================================
  // Scenarios
  initial
  begin
    for (int i = 0; i < ROUTERS; i++)
    begin
      pb[i]     = 16'h0150 + 16'(i * 64);
      e_feed[i] = 3'h0;
      e_tune[i] = 10'h000;
      e_tone[i] = 18'h0;
    end
    e_sleep = 8'h00;
    e_ten   = 8'h00;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk_routers();
    change(3, 3'h5, 10'h2A7, FRAMING_NO_REPLY, SLAVE_ADDR_RESET);
    for (int f = 0; f < 8; f++)
      change(f, 3'(f), 10'(f * 99 + 1), FRAMING_REPLY, BROADCAST_ADDR);
    e_sleep[3] = 1'b1;
    run(FRAMING_NO_REPLY, slave_address, CMD_OPERATION, 8'h6C, DATA_ZERO, 1'b1, 0);
    probe(2, SUB_APP, 8'h04, 1'b1);
    probe(5, SUB_APP, 8'h05, 1'b0);
    probe(4, SUB_OSC, 8'h03, 1'b1);
    probe(6, SUB_OSC, 8'h07, 1'b0);
    stb.send({FRAMING_NO_REPLY, slave_address, CMD_OPERATION, 8'h25, 8'h10}, 4, 0);
    @(posedge core_clk);
    #1;
    chk("short_done", 18'h0, {17'h0, cmd_done | cmd_ignored});
    run(8'hE4, slave_address, CMD_OPERATION, 8'h25, 8'h10, 1'b0, 0);
    run(FRAMING_NO_REPLY, 8'h12, CMD_OPERATION, 8'h25, 8'h10, 1'b0, 0);
    run(FRAMING_NO_REPLY, slave_address, CMD_INSTALLATION, 8'h29, 8'h04, 1'b0, 0);
    for (int i = 0; i < ROUTERS; i++)
    begin
      e_ten[i]   = 1'b1;
      e_sleep[i] = 1'b0;
      e_tone[i]  = {1'b0, pb[i], 1'b0};
    end
    run(FRAMING_REPLY, BROADCAST_ADDR, CMD_INSTALLATION, 8'hE0, 8'h5C, 1'b1, 0);
    @(posedge core_clk);
    legacy_matrix_en <= 1'b1;
    run(FRAMING_NO_REPLY, slave_address, CMD_OPERATION, 8'h39, 8'h10, 1'b0, 0);
    change(1, 3'h2, 10'h110, FRAMING_NO_REPLY, SLAVE_ADDR_RESET);
    close_out();
  end
endmodule
